// [core/pcg_pkg.sv]
// Package: register map, reset values and field positions for the port C block
package pcg_pkg;

  // Register byte offsets
  localparam logic [3:0] OFS_PIN_LEVELS    = 4'h0;
  localparam logic [3:0] OFS_OUTPUT_LATCH  = 4'h4;
  localparam logic [3:0] OFS_DIRECTION     = 4'h8;
  localparam logic [3:0] OFS_PERIPH_CTRL   = 4'hC;

  // Widths
  localparam int PORT_W = 8;
  localparam int ADDR_W = 4;

  // Reset values
  localparam logic [7:0] DIR_RESET   = 8'hFF;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [4:0] CTRL_RESET  = 5'h10;

  // Peripheral control register bit positions
  localparam int CTRL_OSC_EN     = 0;
  localparam int CTRL_CC1_OUT_EN = 1;
  localparam int CTRL_CC2_OUT_EN = 2;
  localparam int CTRL_EPWM_EN    = 3;
  localparam int CTRL_CC2_SEL    = 4;
  localparam int CTRL_W          = 5;

  // Pin positions
  localparam int PIN_OSC_OUT = 0;
  localparam int PIN_OSC_IN  = 1;
  localparam int PIN_CC2     = 1;
  localparam int PIN_CC1     = 2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [core/pcg_pin_mux.sv]
// Pin multiplexer: direction and data override per pin, registered outputs
`timescale 1ns/100ps

module pcg_pin_mux #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Software state
  input  wire logic [WIDTH-1:0] dir_bits,
  input  wire logic [WIDTH-1:0] latch_bits,
  // Peripheral controls
  input  wire logic             osc_en,
  input  wire logic             cc1_out_en,
  input  wire logic             cc1_out,
  input  wire logic             cc2_out_en,
  input  wire logic             cc2_out,
  input  wire logic             cc2_on_pin1,
  // Pad drive
  output logic      [WIDTH-1:0] pad_out,
  output logic      [WIDTH-1:0] pad_oe
);

  typedef struct packed {
    logic [WIDTH-1:0] out;
    logic [WIDTH-1:0] oe;
  } pcg_mux_state_t;

  pcg_mux_state_t st_reg;
  pcg_mux_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.oe  = ~dir_bits;
    st_next.out = latch_bits & ~dir_bits;
    if (!dir_bits[pcg_pkg::PIN_CC1] && cc1_out_en) begin
      st_next.out[pcg_pkg::PIN_CC1] = cc1_out;
    end
    if (cc2_on_pin1 && !dir_bits[pcg_pkg::PIN_CC2] && cc2_out_en) begin
      st_next.out[pcg_pkg::PIN_CC2] = cc2_out;
    end
    if (osc_en) begin
      st_next.oe[pcg_pkg::PIN_OSC_OUT]  = 1'b0;
      st_next.oe[pcg_pkg::PIN_OSC_IN]   = 1'b0;
      st_next.out[pcg_pkg::PIN_OSC_OUT] = 1'b0;
      st_next.out[pcg_pkg::PIN_OSC_IN]  = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pad_out = st_reg.out;
  assign pad_oe  = st_reg.oe;

endmodule

// [core/pcg_port_c.sv]
// Port C general-purpose I/O with peripheral overrides and AXI4-Lite registers
`timescale 1ns/100ps

// Summary of operation
// - Eight pins, each separately set as input or output.
// - Direction bit one makes the pin an input, driver released.
// - Direction bit zero drives the pin from the output latch bit.
// - Latch register is addressable; reads return latch, not pin levels.
// - Enabled peripherals may force pin direction regardless of stored bit.
// - Direction reads return stored bits even during peripheral override.
// - Reset makes every pin a digital input.
// - Select bit one routes unit 2 to pin 1; zero routes elsewhere.
// - Oscillator enabled turns pins 0 and 1 analog, digital I/O off.
// - Pin 0 feeds the counter timers' external input when direction one.
// - Unit 2 on pin 1: output beats latch, or pin feeds capture.
// - Pin 2: unit 1 output beats latch, or pin feeds capture.
// - Input pin level appears in the pin-levels register bit.
// - Output pin presents its output latch bit.
module pcg_port_c #(
  parameter int          WIDTH       = 8,
  parameter logic [4:0]  CTRL_INIT   = 5'h10
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // AXI4-Lite write address
  input  wire logic [3:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]       s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  // AXI4-Lite read data
  output logic      [31:0]      s_axi_rdata,
  output logic      [1:0]       s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Pins
  input  wire logic [WIDTH-1:0] pad_in,
  output logic      [WIDTH-1:0] pad_out,
  output logic      [WIDTH-1:0] pad_oe,
  // Capture/compare unit 1
  input  wire logic             cc1_out,
  output logic                  cc1_capture_in,
  // Capture/compare unit 2
  input  wire logic             cc2_out,
  output logic                  cc2_capture_in,
  output logic                  cc2_on_port_c,
  // Counter timers and oscillator
  output logic                  counter_timers_ext_input,
  output logic                  low_freq_osc_en
);

  typedef struct packed {
    logic [WIDTH-1:0]           sync1;
    logic [WIDTH-1:0]           sync2;
    logic [WIDTH-1:0]           dir;
    logic [WIDTH-1:0]           latch;
    logic [pcg_pkg::CTRL_W-1:0] ctrl;
    logic                       aw_full;
    logic [3:0]                 aw_addr;
    logic                       w_full;
    logic [31:0]                w_data;
    logic [3:0]                 w_strb;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    logic                       cc1_cap;
    logic                       cc2_cap;
    logic                       t_ext;
  } pcg_state_t;

  pcg_state_t st_reg;
  pcg_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////

  // Byte-lane merge of a register byte
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [31:0] data,
                                            input logic [3:0] strb);
    merge_byte = strb[0] ? data[7:0] : old_v;
  endfunction

  // Decode of a word offset
  function automatic logic is_mapped(input logic [3:0] addr);
    is_mapped = (addr == pcg_pkg::OFS_PIN_LEVELS) || (addr == pcg_pkg::OFS_OUTPUT_LATCH) ||
                (addr == pcg_pkg::OFS_DIRECTION) || (addr == pcg_pkg::OFS_PERIPH_CTRL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  logic             do_write;
  logic             do_read;
  logic [WIDTH-1:0] pin_levels;

  always_comb begin
    st_next  = st_reg;
    do_write = 1'b0;
    do_read  = 1'b0;
    st_next.sync1 = pad_in;
    st_next.sync2 = st_reg.sync1;
    pin_levels = st_reg.sync2;
    if (st_reg.ctrl[pcg_pkg::CTRL_OSC_EN]) begin
      pin_levels[pcg_pkg::PIN_OSC_OUT] = 1'b0;
      pin_levels[pcg_pkg::PIN_OSC_IN]  = 1'b0;
    end

    // Write address and data capture
    if (s_axi_awvalid && !st_reg.aw_full) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_full) begin
      st_next.w_full = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end

    // Write commit
    if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid) begin
      do_write        = 1'b1;
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = is_mapped(st_reg.aw_addr) ? pcg_pkg::RESP_OKAY : pcg_pkg::RESP_SLVERR;
      unique case (st_reg.aw_addr)
        pcg_pkg::OFS_PIN_LEVELS: begin
          st_next.latch = merge_byte(st_reg.latch, st_reg.w_data, st_reg.w_strb);
        end
        pcg_pkg::OFS_OUTPUT_LATCH: begin
          st_next.latch = merge_byte(st_reg.latch, st_reg.w_data, st_reg.w_strb);
        end
        pcg_pkg::OFS_DIRECTION: begin
          st_next.dir = merge_byte(st_reg.dir, st_reg.w_data, st_reg.w_strb);
        end
        pcg_pkg::OFS_PERIPH_CTRL: begin
          if (st_reg.w_strb[0]) begin
            st_next.ctrl = st_reg.w_data[pcg_pkg::CTRL_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // Read
    if (s_axi_arvalid && !st_reg.rvalid) begin
      do_read        = 1'b1;
      st_next.rvalid = 1'b1;
      st_next.rdata  = 32'h0000_0000;
      st_next.rresp  = is_mapped(s_axi_araddr) ? pcg_pkg::RESP_OKAY : pcg_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        pcg_pkg::OFS_PIN_LEVELS: begin
          st_next.rdata[WIDTH-1:0] = pin_levels;
        end
        pcg_pkg::OFS_OUTPUT_LATCH: begin
          st_next.rdata[WIDTH-1:0] = st_reg.latch;
        end
        pcg_pkg::OFS_DIRECTION: begin
          st_next.rdata[WIDTH-1:0] = st_reg.dir;
        end
        pcg_pkg::OFS_PERIPH_CTRL: begin
          st_next.rdata[pcg_pkg::CTRL_W-1:0] = st_reg.ctrl;
        end
        default: begin
        end
      endcase
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    st_next.t_ext = st_reg.dir[pcg_pkg::PIN_OSC_OUT] && !st_reg.ctrl[pcg_pkg::CTRL_OSC_EN] &&
                    st_reg.sync2[pcg_pkg::PIN_OSC_OUT];
    st_next.cc1_cap = st_reg.dir[pcg_pkg::PIN_CC1] && st_reg.sync2[pcg_pkg::PIN_CC1];
    st_next.cc2_cap = st_reg.ctrl[pcg_pkg::CTRL_CC2_SEL] && st_reg.dir[pcg_pkg::PIN_CC2] &&
                      !st_reg.ctrl[pcg_pkg::CTRL_OSC_EN] && st_reg.sync2[pcg_pkg::PIN_CC2];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg       <= '0;
      st_reg.dir   <= pcg_pkg::DIR_RESET;
      st_reg.latch <= pcg_pkg::LATCH_RESET;
      st_reg.ctrl  <= CTRL_INIT;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  pcg_pin_mux #(
    .WIDTH (WIDTH)
  ) u_pin_mux (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .dir_bits    (st_reg.dir),
    .latch_bits  (st_reg.latch),
    .osc_en      (st_reg.ctrl[pcg_pkg::CTRL_OSC_EN]),
    .cc1_out_en  (st_reg.ctrl[pcg_pkg::CTRL_CC1_OUT_EN] | st_reg.ctrl[pcg_pkg::CTRL_EPWM_EN]),
    .cc1_out     (cc1_out),
    .cc2_out_en  (st_reg.ctrl[pcg_pkg::CTRL_CC2_OUT_EN]),
    .cc2_out     (cc2_out),
    .cc2_on_pin1 (st_reg.ctrl[pcg_pkg::CTRL_CC2_SEL]),
    .pad_out     (pad_out),
    .pad_oe      (pad_oe)
  );

  // Bus and peripheral outputs from flops
  assign s_axi_awready            = !st_reg.aw_full;
  assign s_axi_wready             = !st_reg.w_full;
  assign s_axi_bvalid             = st_reg.bvalid;
  assign s_axi_bresp              = st_reg.bresp;
  assign s_axi_arready            = !st_reg.rvalid;
  assign s_axi_rvalid             = st_reg.rvalid;
  assign s_axi_rdata              = st_reg.rdata;
  assign s_axi_rresp              = st_reg.rresp;
  assign cc1_capture_in           = st_reg.cc1_cap;
  assign cc2_capture_in           = st_reg.cc2_cap;
  assign cc2_on_port_c            = st_reg.ctrl[pcg_pkg::CTRL_CC2_SEL];
  assign counter_timers_ext_input = st_reg.t_ext;
  assign low_freq_osc_en          = st_reg.ctrl[pcg_pkg::CTRL_OSC_EN];

endmodule

// [testbench/pcg_board_model.sv]
// Board model: pin levels and peripheral outputs seen by port C
`timescale 1ns/100ps
module pcg_board_model (
  // Port drive
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  // Board and peripheral levels
  input  wire logic [7:0] ext_lvl,
  input  wire logic       cc1_lvl,
  input  wire logic       cc2_lvl,
  // Seen by the port
  output logic      [7:0] pad_in,
  output logic            cc1_out,
  output logic            cc2_out
);
  // Driven pins carry the port level, others the board level
  assign pad_in  = (pad_out & pad_oe) | (ext_lvl & ~pad_oe);
  assign cc1_out = cc1_lvl;
  assign cc2_out = cc2_lvl;
endmodule

// [testbench/pcg_port_c_props.sv]
// Checker for port C pins and bus
`timescale 1ns/100ps
module pcg_port_c_props (
  // Clock, reset and bus
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  // Pins and peripherals
  input wire logic [7:0] pad_in,
  input wire logic [7:0] pad_oe,
  input wire logic       cc1_capture_in,
  input wire logic       cc2_capture_in,
  input wire logic       cc2_on_port_c,
  input wire logic       counter_timers_ext_input,
  input wire logic       low_freq_osc_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  property p_rst; disable iff (1'h0) !aresetn |=> pad_oe == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("pins driven after reset");
  property p_osc; low_freq_osc_en && $past(low_freq_osc_en) && $past(low_freq_osc_en, 2)
    |-> pad_oe[1:0] == 2'h0; endproperty
  a_osc: assert property (p_osc) else $error("osc pins driven");
  property p_osc_io; low_freq_osc_en && $past(low_freq_osc_en) && $past(low_freq_osc_en, 2)
    |-> !counter_timers_ext_input && !cc2_capture_in; endproperty
  a_osc_io: assert property (p_osc_io) else $error("osc pins feed inputs");
  property p_sel; !cc2_on_port_c && !$past(cc2_on_port_c) && !$past(cc2_on_port_c, 2)
    |-> !cc2_capture_in; endproperty
  a_sel: assert property (p_sel) else $error("unit 2 capture while routed away");
  property p_ext; counter_timers_ext_input |-> $past(pad_in[0], 3); endproperty
  a_ext: assert property (p_ext) else $error("counter input not from pin 0");
  property p_cap1; cc1_capture_in |-> $past(pad_in[2], 3); endproperty
  a_cap1: assert property (p_cap1) else $error("unit 1 capture not from pin 2");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_rhold: assert property (p_rhold) else $error("rvalid dropped");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  c_osc: cover property (low_freq_osc_en);
  c_cap: cover property (cc1_capture_in && counter_timers_ext_input);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind pcg_port_c pcg_port_c_props u_props (.*);

// [testbench/tb_top.sv]
// Self-checking testbench for the port C block
`timescale 1ns/100ps
module tb_top;
  localparam logic [3:0] A_PIN = pcg_pkg::OFS_PIN_LEVELS;
  localparam logic [3:0] A_LAT = pcg_pkg::OFS_OUTPUT_LATCH;
  localparam logic [3:0] A_DIR = pcg_pkg::OFS_DIRECTION;
  localparam logic [3:0] A_CTL = pcg_pkg::OFS_PERIPH_CTRL;
  localparam logic [1:0] OK    = pcg_pkg::RESP_OKAY;
  localparam logic [1:0] ERR   = pcg_pkg::RESP_SLVERR;
  logic        aclk = 1'h0, aresetn = 1'h0, cc1_lvl = 1'h0, cc2_lvl = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [7:0]  ext_lvl = 8'h00, pad_in, pad_out, pad_oe;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        cc1_out, cc2_out, cc1_capture_in, cc2_capture_in, cc2_on_port_c;
  logic        counter_timers_ext_input, low_freq_osc_en;
  int          errors = 0, cmp_count = 0;
  pcg_port_c uut (.*);
  pcg_board_model board (.*);
  initial begin
    forever #50 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic [2:0] tk;
    logic v, b;
    logic [1:0] r;
    logic [31:0] q;
    b = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    for (n = 0; n < 60 && !b; n++) begin
      @(negedge aclk);
      tk = {s_axi_awvalid && s_axi_awready, s_axi_wvalid && s_axi_wready, s_axi_arvalid && s_axi_arready};
      v = wr ? s_axi_bvalid : s_axi_rvalid;
      b = v && (wr ? s_axi_bready : s_axi_rready);
      r = wr ? s_axi_bresp : s_axi_rresp;
      q = s_axi_rdata;
      @(posedge aclk);
      if (tk[2]) s_axi_awvalid <= 1'h0;
      if (tk[1]) s_axi_wvalid <= 1'h0;
      if (tk[0]) s_axi_arvalid <= 1'h0;
      if (v && wr) s_axi_bready <= !b;
      if (v && !wr) s_axi_rready <= !b;
    end
    if (!b) begin
      errors++;
      wrap_up;
    end
    chk(32'(r), 32'(er));
    if (!wr) chk(q, d);
  endtask
  ////////////////////////////////////////////////////////////
  task t_reset;
    xfer(1'h0, A_DIR, 32'hFF, OK);
    xfer(1'h0, A_LAT, 32'h00, OK);
    xfer(1'h0, A_CTL, 32'h10, OK);
    chk(32'(pad_oe), 32'h00);
    xfer(1'h0, 4'h2, 32'h00, ERR);
    xfer(1'h1, 4'h2, 32'hFF, ERR);
    $display("reset test done");
  endtask
  task t_pins;
    xfer(1'h1, A_LAT, 32'hA5, OK);
    xfer(1'h1, A_DIR, 32'h00, OK);
    ext_lvl <= 8'h3C;
    repeat (6) @(posedge aclk);
    chk(32'(pad_oe), 32'hFF);
    chk(32'(pad_out), 32'hA5);
    xfer(1'h0, A_PIN, 32'hA5, OK);
    xfer(1'h1, A_DIR, 32'hF0, OK);
    repeat (6) @(posedge aclk);
    chk(32'(pad_oe), 32'h0F);
    xfer(1'h0, A_PIN, 32'h35, OK);
    xfer(1'h0, A_LAT, 32'hA5, OK);
    xfer(1'h1, A_PIN, 32'hFFFFFF5A, OK);
    xfer(1'h0, A_LAT, 32'h5A, OK);
    $display("pin test done");
  endtask
  task t_periph;
    ext_lvl <= 8'hFF;
    cc1_lvl <= 1'h1;
    cc2_lvl <= 1'h1;
    xfer(1'h1, A_DIR, 32'h00, OK);
    xfer(1'h1, A_LAT, 32'h00, OK);
    xfer(1'h1, A_CTL, 32'h11, OK);
    repeat (6) @(posedge aclk);
    chk(32'(pad_oe), 32'hFC);
    xfer(1'h0, A_PIN, 32'h00, OK);
    xfer(1'h0, A_DIR, 32'h00, OK);
    xfer(1'h1, A_CTL, 32'h16, OK);
    repeat (6) @(posedge aclk);
    chk(32'(pad_out & pad_oe), 32'h06);
    xfer(1'h1, A_CTL, 32'h0C, OK);
    repeat (6) @(posedge aclk);
    chk(32'(pad_out & pad_oe), 32'h04);
    chk(32'(cc2_on_port_c), 32'h0);
    xfer(1'h1, A_DIR, 32'hFF, OK);
    xfer(1'h1, A_CTL, 32'h10, OK);
    ext_lvl <= 8'h07;
    repeat (6) @(posedge aclk);
    chk({29'h0, counter_timers_ext_input, cc1_capture_in, cc2_capture_in}, 32'h7);
    chk(32'(pad_oe), 32'h00);
    xfer(1'h1, A_CTL, 32'h11, OK);
    repeat (6) @(posedge aclk);
    chk({30'h0, counter_timers_ext_input, cc2_capture_in}, 32'h0);
    xfer(1'h0, A_DIR, 32'hFF, OK);
    $display("peripheral test done");
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_pins;
    t_periph;
    wrap_up;
  end
endmodule
